// ---- mxm_datapath.sv ----
// Datapath for string move tail, sign/zero extend moves, unsigned multiply
`timescale 1ns/10ps

module mxm_datapath
    import mxm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Request
    input wire logic req_valid,
    input wire req_t req,
    input wire chk_t chk,
    // Result
    output logic done,
    output res_t res,
    output fault_t fault
);

    typedef struct packed {
        logic done;
        res_t res;
        fault_t fault;
    } state_t;

    state_t cur;
    state_t next_cur;
    fault_t fault_now;
    logic mem_used;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] step_of(input size_t_t sz);
        case (sz)
            SZ_BYTE: step_of = STEP_BYTE;
            SZ_WORD: step_of = STEP_WORD;
            default: step_of = STEP_DWORD;
        endcase
    endfunction

    function automatic logic [31:0] extend(input logic [31:0] v,
                                           input size_t_t ssz,
                                           input size_t_t dsz,
                                           input logic sgn);
        logic [31:0] r;
        r = '0;
        if (ssz == SZ_BYTE) begin
            r = {{24{sgn & v[7]}}, v[7:0]};
        end else begin
            r = {{16{sgn & v[15]}}, v[15:0]};
        end
        // A 16-bit destination keeps the upper register bits untouched
        // by the register file; we deliver zeros above bit 15
        if (dsz == SZ_WORD) begin
            r = {16'h0000, r[15:0]};
        end
        extend = r;
    endfunction

    assign mem_used = (req.op == OP_STRING_MOVE) || req.src_is_mem;

    mxm_fault_check u_fault (
        .op(req.op),
        .mem_used(mem_used),
        .chk(chk),
        .fault(fault_now)
    );

    // ==========================================================
    // Next state
    logic [31:0] src;
    logic [31:0] step;
    logic [63:0] prod;

    always_comb begin
        next_cur = '0;
        src = req.src_is_mem ? req.src_mem : req.src_reg;
        step = step_of(req.src_size);
        prod = 64'h0000_0000_0000_0000;
        case (req.src_size)
            // Operands widened first: a bare product keeps only its
            // operands' width inside a concatenation
            SZ_BYTE: prod = {48'h0, 16'(req.acc[7:0]) * 16'(src[7:0])};
            SZ_WORD: prod = {32'h0, 32'(req.acc[15:0]) * 32'(src[15:0])};
            default: prod = 64'(req.acc) * 64'(src);
        endcase
        if (req_valid) begin
            next_cur.done = 1'b1;
            next_cur.fault = fault_now;
            if (!(fault_now.gp_fault || fault_now.ss_fault ||
                  fault_now.pf_fault || fault_now.ac_fault)) begin
                case (req.op)
                    OP_STRING_MOVE: begin
                        next_cur.res.wr_index = 1'b1;
                        if (!req.dir_flag) begin
                            next_cur.res.src_index = req.src_index + step;
                            next_cur.res.dst_index = req.dst_index + step;
                        end else begin
                            next_cur.res.src_index = req.src_index - step;
                            next_cur.res.dst_index = req.dst_index - step;
                        end
                    end
                    OP_SIGN_EXT: begin
                        next_cur.res.wr_dst = 1'b1;
                        next_cur.res.dst = extend(src, req.src_size,
                                                  req.dst_size, 1'b1);
                    end
                    OP_ZERO_EXT: begin
                        next_cur.res.wr_dst = 1'b1;
                        next_cur.res.dst = extend(src, req.src_size,
                                                  req.dst_size, 1'b0);
                    end
                    OP_MULTIPLY: begin
                        next_cur.res.wr_acc = 1'b1;
                        next_cur.res.wr_flags = 1'b1;
                        // Other arithmetic flags are not driven at all
                        case (req.src_size)
                            SZ_BYTE: begin
                                next_cur.res.acc = prod[31:0];
                                next_cur.res.carry_flag =
                                    (prod[15:8] != 8'h00);
                            end
                            SZ_WORD: begin
                                next_cur.res.wr_ext = 1'b1;
                                next_cur.res.acc = {16'h0000, prod[15:0]};
                                next_cur.res.ext = {16'h0000, prod[31:16]};
                                next_cur.res.carry_flag =
                                    (prod[31:16] != 16'h0000);
                            end
                            default: begin
                                next_cur.res.wr_ext = 1'b1;
                                next_cur.res.acc = prod[31:0];
                                next_cur.res.ext = prod[63:32];
                                next_cur.res.carry_flag =
                                    (prod[63:32] != 32'h0);
                            end
                        endcase
                        next_cur.res.overflow_flag =
                            next_cur.res.carry_flag;
                    end
                    default: begin
                        next_cur.done = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign done = cur.done;
    assign res = cur.res;
    assign fault = cur.fault;

    // ==========================================================
    // Checks
    logic any_fault;
    assign any_fault = cur.fault.gp_fault | cur.fault.ss_fault |
                       cur.fault.pf_fault | cur.fault.ac_fault;

    property p_step;
        @(posedge clk_sys) disable iff (rst)
        req_valid && req.op == OP_STRING_MOVE && !fault_now.gp_fault &&
        !fault_now.ss_fault && !fault_now.pf_fault && !fault_now.ac_fault
        |=> res.src_index == ($past(req.dir_flag) ?
            $past(req.src_index) - $past(step) :
            $past(req.src_index) + $past(step));
    endproperty
    a_step: assert property (p_step)
        else $error("string index step wrong");

    property p_suppress;
        @(posedge clk_sys) disable iff (rst)
        any_fault |-> !(res.wr_dst || res.wr_acc || res.wr_ext ||
                        res.wr_index || res.wr_flags);
    endproperty
    a_suppress: assert property (p_suppress)
        else $error("update on faulting instruction");

    property p_flags;
        @(posedge clk_sys) disable iff (rst)
        res.wr_flags |-> res.carry_flag == res.overflow_flag &&
            res.carry_flag == (res.ext != 32'h0 || (!res.wr_ext &&
            res.acc[15:8] != 8'h00));
    endproperty
    a_flags: assert property (p_flags)
        else $error("multiply flags wrong");

    property p_ac_cpl;
        @(posedge clk_sys) disable iff (rst)
        req_valid && mem_used && chk.mode == MODE_PROT && chk.cpl != CPL_USER
        |=> !fault.ac_fault;
    endproperty
    a_ac_cpl: assert property (p_ac_cpl)
        else $error("alignment fault below privilege 3");

    property p_ac_v86;
        @(posedge clk_sys) disable iff (rst)
        fault.ac_fault && $past(chk.mode) == MODE_V86 |->
            fault.has_code && fault.code == ERR_ZERO;
    endproperty
    a_ac_v86: assert property (p_ac_v86)
        else $error("v86 alignment fault code wrong");

    property p_real_gp;
        @(posedge clk_sys) disable iff (rst)
        fault.gp_fault && $past(chk.mode) == MODE_REAL |-> !fault.has_code;
    endproperty
    a_real_gp: assert property (p_real_gp)
        else $error("real mode gp fault with code");

    property p_pf;
        @(posedge clk_sys) disable iff (rst)
        req_valid && mem_used && chk.mode != MODE_REAL && chk.page_fault &&
        !chk.data_limit_err && !chk.null_selector && !chk.stack_limit_err &&
        !chk.dst_not_writable
        |=> fault.pf_fault && fault.code == $past(chk.page_code);
    endproperty
    a_pf: assert property (p_pf)
        else $error("page fault lost");

    property p_ss;
        @(posedge clk_sys) disable iff (rst)
        fault.ss_fault |-> fault.code == ERR_ZERO && !fault.gp_fault;
    endproperty
    a_ss: assert property (p_ss)
        else $error("stack fault code wrong");

    property p_zext;
        @(posedge clk_sys) disable iff (rst)
        res.wr_dst && $past(req.op) == OP_ZERO_EXT &&
        $past(req.src_size) == SZ_BYTE |-> res.dst[31:8] == 24'h0;
    endproperty
    a_zext: assert property (p_zext)
        else $error("zero extend upper bits set");

    c_mul: cover property (@(posedge clk_sys) res.wr_ext && res.carry_flag);
    c_str: cover property (@(posedge clk_sys) res.wr_index);
    c_gp: cover property (@(posedge clk_sys) fault.gp_fault);
    c_sx: cover property (@(posedge clk_sys) res.wr_dst && res.dst[31]);

endmodule

// ---- mxm_pkg.sv ----
// Shared types and constants for the move/extend/multiply datapath
package mxm_pkg;

    // ==========================================================
    // Operation codes and sizes
    typedef enum logic [2:0] {
        OP_NONE,
        OP_STRING_MOVE,
        OP_SIGN_EXT,
        OP_ZERO_EXT,
        OP_MULTIPLY
    } op_t;

    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_DWORD
    } size_t_t;

    typedef enum logic [1:0] {
        MODE_REAL,
        MODE_PROT,
        MODE_V86
    } cpu_mode_t;

    // ==========================================================
    // Constants
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_DWORD = 32'h0000_0004;
    localparam logic [1:0] CPL_USER = 2'h3;
    localparam logic [15:0] ERR_ZERO = 16'h0000;

    // ==========================================================
    // Request from the decoder and memory unit
    typedef struct packed {
        op_t op;
        size_t_t src_size;
        size_t_t dst_size;
        logic src_is_mem;
        logic [31:0] src_reg;
        logic [31:0] src_mem;
        logic [31:0] acc;
        logic [31:0] src_index;
        logic [31:0] dst_index;
        logic dir_flag;
    } req_t;

    // Memory check results for the operand access
    typedef struct packed {
        cpu_mode_t mode;
        logic [1:0] cpl;
        logic align_check;
        logic unaligned;
        logic dst_not_writable;
        logic data_limit_err;
        logic null_selector;
        logic stack_limit_err;
        logic page_fault;
        logic [15:0] page_code;
    } chk_t;

    // Fault outcome
    typedef struct packed {
        logic gp_fault;
        logic ss_fault;
        logic pf_fault;
        logic ac_fault;
        logic has_code;
        logic [15:0] code;
    } fault_t;

    // Result toward the register file
    typedef struct packed {
        logic wr_dst;
        logic [31:0] dst;
        logic wr_acc;
        logic [31:0] acc;
        logic wr_ext;
        logic [31:0] ext;
        logic wr_index;
        logic [31:0] src_index;
        logic [31:0] dst_index;
        logic wr_flags;
        logic carry_flag;
        logic overflow_flag;
    } res_t;

endpackage

// ---- mxm_fault_check.sv ----
// Fault classification for memory operands
`timescale 1ns/10ps

module mxm_fault_check
    import mxm_pkg::*;
(
    // Operand
    input wire op_t op,
    input wire logic mem_used,
    input wire chk_t chk,
    // Outcome
    output fault_t fault
);

    logic prot;
    logic v86;

    always_comb begin
        prot = (chk.mode == MODE_PROT);
        v86 = (chk.mode == MODE_V86);
        fault = '0;
        if (mem_used) begin
            // Priority: gp, ss, pf, ac
            if (prot && op == OP_STRING_MOVE && chk.dst_not_writable) begin
                fault.gp_fault = 1'b1;
                fault.has_code = 1'b1;
            end else if (prot && chk.null_selector) begin
                fault.gp_fault = 1'b1;
                fault.has_code = 1'b1;
            end else if (chk.data_limit_err) begin
                fault.gp_fault = 1'b1;
                fault.has_code = (chk.mode != MODE_REAL);
            end else if (chk.stack_limit_err) begin
                fault.ss_fault = 1'b1;
                fault.has_code = (chk.mode != MODE_REAL);
            end else if ((prot || v86) && chk.page_fault) begin
                fault.pf_fault = 1'b1;
                fault.has_code = 1'b1;
                fault.code = chk.page_code;
            end else if (chk.align_check && chk.unaligned &&
                         ((prot && chk.cpl == CPL_USER) || v86)) begin
                fault.ac_fault = 1'b1;
                fault.has_code = 1'b1;
            end
        end
        if (!fault.pf_fault) begin
            fault.code = ERR_ZERO;
        end
    end

endmodule

// ---- decode_model.sv ----
// Decoder and memory unit stand-in that feeds the datapath
`timescale 1ns/10ps

module decode_model
    import mxm_pkg::*;
(
    // Toward the datapath
    output logic req_valid,
    output req_t req,
    output chk_t chk
);
    // ==========================================================
    // Request lines
    initial begin
        req_valid = 1'b0;
        req = '0;
        chk = '0;
    end

    // Caller sits just after a rising edge; the request holds until idle
    task automatic send(input req_t r, input chk_t c);
        req_valid = 1'b1;
        req = r;
        chk = c;
    endtask

    // Released lines flip so that a stale operand can never look valid
    task automatic idle();
        req_valid = 1'b0;
        req = ~req;
        chk = ~chk;
    endtask
endmodule

// ---- tb_mxm_datapath.sv ----
// Self-checking bench for the move/extend/multiply datapath
`timescale 1ns/10ps

module tb_mxm_datapath
    import mxm_pkg::*;
;
    logic clk_sys;
    logic rst;
    logic req_valid;
    req_t req;
    chk_t chk;
    logic done;
    res_t res;
    fault_t fault;
    res_t sm;
    int bad_count;
    int checks;

    mxm_datapath dut_u (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
        .req(req), .chk(chk), .done(done), .res(res), .fault(fault));
    decode_model m_u (.req_valid(req_valid), .req(req), .chk(chk));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Checking
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic note(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic cmp_done(input logic e);
        note(done === e, "done");
    endtask

    // Data fields only matter where their strobe is expected
    task automatic cmp_res(input res_t e, input res_t m);
        note((res & m) === (e & m), "result");
    endtask

    task automatic cmp_fault(input fault_t e);
        fault_t m;
        m = '1;
        m.code = e.has_code ? 16'hFFFF : 16'h0000;
        note((fault & m) === (e & m), "fault");
    endtask

    // ==========================================================
    // Access
    function automatic req_t mk(op_t op, size_t_t s, size_t_t d, logic mem,
        logic [31:0] rg, logic [31:0] mv, logic [31:0] a, logic [31:0] si,
        logic [31:0] di, logic df);
        mk = '{op, s, d, mem, rg, mv, a, si, di, df};
    endfunction

    // Result is registered on the taking edge and checked 1 ns after it
    task automatic issue(input req_t r, input chk_t c);
        m_u.send(r, c);
        @(posedge clk_sys);
        #1;
        cmp_done(1'b1);
    endtask

    task automatic rest();
        m_u.idle();
        @(posedge clk_sys);
        #1;
        cmp_done(1'b0);
    endtask

    task automatic do_str(input size_t_t sz, input logic df);
        logic [31:0] st;
        st = sz == SZ_BYTE ? STEP_BYTE :
             sz == SZ_WORD ? STEP_WORD : STEP_DWORD;
        if (df) begin
            st = -st;
        end
        issue(mk(OP_STRING_MOVE, sz, sz, '1, '0, '0, '0, 32'h0000_0001,
            32'hFFFF_FFFE, df), '0);
        cmp_res('{'0, '0, '0, '0, '0, '0, '1, 32'h0000_0001 + st,
            32'hFFFF_FFFE + st, '0, '0, '0},
            '{'1, '0, '1, '0, '1, '0, '1, '1, '1, '1, '0, '0});
    endtask

    task automatic do_ext(input op_t op, input size_t_t s, input size_t_t d,
        input logic mem, input logic [31:0] v, input logic [31:0] x);
        issue(mk(op, s, d, mem, mem ? ~v : v, mem ? v : ~v, '0, '0, '0, '0),
            '0);
        cmp_res('{'1, x, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0},
            '{'1, '1, '1, '0, '1, '0, '1, '0, '0, '1, '0, '0});
    endtask

    task automatic do_mul(input size_t_t sz, input logic mem,
        input logic [31:0] a, input logic [31:0] s);
        logic [31:0] w;
        logic [63:0] p;
        logic [31:0] xv;
        logic [31:0] am;
        logic hi;
        w = sz == SZ_BYTE ? 32'hFF : sz == SZ_WORD ? 32'hFFFF : 32'hFFFF_FFFF;
        p = 64'(a & w) * 64'(s & w);
        hi = sz == SZ_BYTE ? |p[15:8] : sz == SZ_WORD ? |p[31:16] : |p[63:32];
        xv = sz == SZ_WORD ? {16'h0000, p[31:16]} : p[63:32];
        am = sz == SZ_DWORD ? 32'hFFFF_FFFF : 32'h0000_FFFF;
        issue(mk(OP_MULTIPLY, sz, sz, mem, mem ? ~s : s, mem ? s : ~s, a, '0,
            '0, '0), '0);
        cmp_res('{'0, '0, '1, p[31:0], sz != SZ_BYTE, xv, '0, '0, '0, '1, hi,
            hi}, '{'1, '0, '1, am, '1, sz == SZ_BYTE ? 32'h0 : am, '1, '0, '0,
            '1, '1, '1});
    endtask

    // Flags: align, unaligned, not writable, limit, null, stack, page
    task automatic fcase(input op_t op, input cpu_mode_t md, input logic [1:0]
        cpl, input logic [6:0] fl, input logic [3:0] fo, input logic hc);
        issue(mk(op, SZ_WORD, SZ_DWORD, '1, 32'h0000_8001, 32'h0000_8001,
            32'h0000_0003, 32'h0000_0010, 32'h0000_0020, '0),
            chk_t'({md, cpl, fl, 16'h00A5}));
        cmp_fault({fo, hc, fo[1] ? 16'h00A5 : ERR_ZERO});
        if (|fo) begin
            cmp_res('0, sm);
        end
    endtask

    // ==========================================================
    // Sequence
    initial begin
        bad_count = 0;
        checks = 0;
        rst = 1'b1;
        sm = '{'1, '0, '1, '0, '1, '0, '1, '0, '0, '1, '0, '0};
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        cmp_done(1'b0);
        for (int k = 0; k < 6; k++) begin
            do_str(size_t_t'(k % 3), 1'(k / 3));
        end
        rest();
        $display("test string_move done");
        do_ext(OP_SIGN_EXT, SZ_BYTE, SZ_WORD, '0, 32'h80, 32'hFF80);
        do_ext(OP_SIGN_EXT, SZ_BYTE, SZ_DWORD, '0, 32'hFFFF_FF7F, 32'h7F);
        do_ext(OP_SIGN_EXT, SZ_BYTE, SZ_DWORD, '1, 32'h80, '1 << 7);
        do_ext(OP_SIGN_EXT, SZ_WORD, SZ_DWORD, '1, 32'h1234_8001,
            32'hFFFF_8001);
        do_ext(OP_ZERO_EXT, SZ_BYTE, SZ_WORD, '1, 32'hFFFF_FF80, 32'h80);
        do_ext(OP_ZERO_EXT, SZ_BYTE, SZ_DWORD, '0, 32'h80, 32'h80);
        do_ext(OP_ZERO_EXT, SZ_WORD, SZ_DWORD, '0, 32'hFFFF_8001,
            32'h8001);
        rest();
        $display("test extend done");
        do_mul(SZ_BYTE, '0, 32'hABCD_12FF, 32'hFF);
        do_mul(SZ_BYTE, '1, 32'hFFFF_FF10, 32'hFFFF_FF0F);
        do_mul(SZ_WORD, '0, 32'h5555_FFFF, 32'h2);
        do_mul(SZ_WORD, '1, 32'h100, 32'hFF);
        do_mul(SZ_DWORD, '0, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        do_mul(SZ_DWORD, '1, 32'h1_0000, 32'hFFFF);
        rest();
        $display("test multiply done");
        fcase(OP_SIGN_EXT, MODE_PROT, 2'h0, 7'h04, 4'h8, 1'b1);
        fcase(OP_ZERO_EXT, MODE_PROT, 2'h0, 7'h08, 4'h8, 1'b1);
        fcase(OP_ZERO_EXT, MODE_REAL, 2'h0, 7'h08, 4'h8, 1'b0);
        fcase(OP_MULTIPLY, MODE_PROT, 2'h0, 7'h0A, 4'h8, 1'b1);
        fcase(OP_MULTIPLY, MODE_REAL, 2'h0, 7'h02, 4'h4, 1'b0);
        fcase(OP_MULTIPLY, MODE_V86, 2'h0, 7'h02, 4'h4, 1'b1);
        fcase(OP_SIGN_EXT, MODE_PROT, 2'h0, 7'h01, 4'h2, 1'b1);
        fcase(OP_MULTIPLY, MODE_V86, 2'h3, 7'h01, 4'h2, 1'b1);
        fcase(OP_SIGN_EXT, MODE_PROT, CPL_USER, 7'h60, 4'h1, 1'b1);
        fcase(OP_SIGN_EXT, MODE_PROT, 2'h2, 7'h60, 4'h0, 1'b0);
        fcase(OP_SIGN_EXT, MODE_PROT, CPL_USER, 7'h20, 4'h0, 1'b0);
        fcase(OP_ZERO_EXT, MODE_V86, 2'h0, 7'h60, 4'h1, 1'b1);
        fcase(OP_STRING_MOVE, MODE_PROT, 2'h0, 7'h10, 4'h8, 1'b1);
        issue(mk(OP_NONE, SZ_BYTE, SZ_BYTE, '0, '1, '1, '1, '1, '1, '1), '0);
        cmp_res('0, sm);
        rest();
        $display("test faults done");
        wrap_up();
    end
endmodule
